// ===== bench/gdreg_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host side of the serial register port, mode 0, msb first
module gdreg_host_model #(
   parameter int HALF = 6                 // sys_clk cycles per sclk half period
) (
   input  wire logic sys_clk,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe,
   output logic      spi_cs_n,
   output logic      spi_sclk,
   output logic      spi_mosi
);
   logic oe_ok;                           // enable stood high through every data bit
   // idle: deselected, clock parked low
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one frame of nbits; a short count makes a frame the device must drop
   task automatic xfer(input logic [23:0] frame, input int nbits, output logic [15:0] rdata);
      rdata = 16'h0000;
      oe_ok = 1'b1;
      @(negedge sys_clk);
      spi_cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         @(negedge sys_clk);
         spi_mosi <= frame[23 - i];
         repeat (HALF) @(negedge sys_clk);
         // data phase: sample just before the rise, well after the fall
         if (i >= 8) begin
            rdata = {rdata[14:0], spi_miso};
            oe_ok = oe_ok & (spi_miso_oe === 1'b1);
         end
         spi_sclk <= 1'b1;
         repeat (HALF) @(negedge sys_clk);
         spi_sclk <= 1'b0;
      end
      repeat (HALF) @(negedge sys_clk);
      spi_cs_n <= 1'b1;
      // released line shows no stale bit, so a lazy sampler cannot pass
      spi_mosi <= ~spi_mosi;
      // gap covers the commit and the output register
      repeat (10) @(negedge sys_clk);
   endtask
endmodule // gdreg_host_model

// ===== bench/test_gate_drive_current_and_amp_gain_regs.sv
`timescale 1ns/1ps
module test_gate_drive_current_and_amp_gain_regs import gdreg_pkg::*;;
   logic        sys_clk, resetn, ce, spi_cs_n, spi_sclk, spi_mosi, cfg_sel;
   logic        spi_miso, spi_miso_oe, ref_div;
   logic [5:0]  hi_sink, lo_sink, hi_eff, lo_eff, gain_a, gain_b, gain_c;
   logic [15:0] mon_one, rd_word;
   int          num_errors, samples_checked;
   integer      seed;                     // fixed so every run repeats
   ////////////////////////////////////////////////////////////////////////////
   gdreg_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .source_current_config_select(cfg_sel),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .high_side_sink_current_code(hi_sink),
      .low_side_sink_current_code(lo_sink), .high_side_source_eff(hi_eff),
      .low_side_source_eff(lo_eff), .reference_divide_select(ref_div),
      .amp_gain_value_a(gain_a), .amp_gain_value_b(gain_b), .amp_gain_value_c(gain_c),
      .supply_monitor_control_one(mon_one));
   gdreg_host_model u_host (.sys_clk(sys_clk), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi));
   // 40 MHz
   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////
   // expected gain for a 4-bit code; everything above 1000b saturates
   function automatic logic [5:0] gain_of(input logic [3:0] code);
      case (code)
         4'h0: return 6'h05;
         4'h1: return 6'h0a;
         4'h2: return 6'h0c;
         4'h3: return 6'h10;
         4'h4: return 6'h14;
         4'h5: return 6'h17;
         4'h6: return 6'h19;
         4'h7: return 6'h1e;
         default: return 6'h28;
      endcase
   endfunction
   // expected source code from sink code and ratio, rounded down
   function automatic logic [5:0] src_of(input logic [5:0] sink, input logic [1:0] ratio);
      logic [7:0] s3;
      s3 = {2'h0, sink} * 8'h03;
      if (sink >= 6'h24) return sink;     // strong sink: ratio has no say
      case (ratio)
         2'h0: return sink;
         2'h1: return s3[7:2];
         2'h2: return {1'h0, sink[5:1]};
         default: return {2'h0, sink[5:2]};
      endcase
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] addr, input logic [15:0] data);
      u_host.xfer({1'b0, addr, data}, 24, rd_word);
   endtask
   // data bits of a read frame are random: the device must ignore them
   task automatic rd(input logic [6:0] addr, input logic [15:0] exp);
      logic [31:0] junk;
      junk = $random(seed);
      u_host.xfer({1'b1, addr, junk[15:0]}, 24, rd_word);
      chk(rd_word, exp);
      // output enable held through the data phase and dropped once idle
      chk({14'h0, u_host.oe_ok, spi_miso_oe}, 16'h0002);
   endtask
   task automatic close_out;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // watchdog: about 70 frames of some 330 cycles each run near 0.6 ms,
   // so 1 ms (40k cycles) leaves margin without hiding a hang
   initial begin
      #1_000_000;
      num_errors++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] v;
      logic [15:0] w;
      seed = 32'ha9e1_9562;
      num_errors = 0;
      samples_checked = 0;
      resetn = 1'b0;
      ce = 1'b1;                          // clock enable held on except for one frame near the end
      cfg_sel = 1'b0;
      repeat (3) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (3) @(negedge sys_clk);
      // reset contents and outputs
      rd(ADDR_SINK_RAT, 16'h0000);
      rd(ADDR_AMP_GAIN, 16'h0000);
      rd(ADDR_MON_ONE, 16'h4002);
      chk(mon_one, 16'h4002);
      chk({10'h0, gain_a}, {10'h0, 6'h05});
      // every gain code on every channel, reserved bits written as ones
      for (int c = 0; c < 16; c++) begin
         v = $random(seed);
         w = {v[15], 3'h7, 4'(c), 4'(c + 5), 4'(c + 11)};
         wr(ADDR_AMP_GAIN, w);
         rd(ADDR_AMP_GAIN, w & 16'h8fff);
         chk({10'h0, gain_a}, {10'h0, gain_of(w[11:8])});
         chk({10'h0, gain_b}, {10'h0, gain_of(w[7:4])});
         chk({10'h0, gain_c}, {10'h0, gain_of(w[3:0])});
         chk({15'h0, ref_div}, {15'h0, w[15]});
      end
      // ratio path: all codes on both sides, edge sink codes first
      for (int k = 0; k < 12; k++) begin
         v = $random(seed);
         w = v[15:0];
         w[15:14] = 2'(k);
         w[7:6] = 2'(k + 1);
         if (k < 4) begin
            w[13:8] = (k < 2) ? 6'h23 : 6'h24;
            w[5:0] = (k < 2) ? 6'h24 : 6'h23;
         end
         wr(ADDR_SINK_RAT, w);
         rd(ADDR_SINK_RAT, w);
         chk({10'h0, hi_sink}, {10'h0, w[13:8]});
         chk({10'h0, lo_sink}, {10'h0, w[5:0]});
         chk({10'h0, hi_eff}, {10'h0, src_of(w[13:8], w[15:14])});
         chk({10'h0, lo_eff}, {10'h0, src_of(w[5:0], w[7:6])});
      end
      // programmed source codes take over while the select pin is high
      v = $random(seed);
      wr(ADDR_SRC_CODE, v[15:0]);
      rd(ADDR_SRC_CODE, v[15:0] & 16'h3f3f);
      cfg_sel = 1'b1;
      wr(ADDR_SINK_RAT, 16'hd5c9);
      chk({10'h0, hi_eff}, {10'h0, v[13:8]});
      chk({10'h0, lo_eff}, {10'h0, v[5:0]});
      cfg_sel = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk({10'h0, hi_eff}, {10'h0, src_of(6'h15, 2'h3)});
      chk({10'h0, lo_eff}, {10'h0, src_of(6'h09, 2'h3)});
      // monitor register, then a short frame that must be dropped
      v = $random(seed);
      wr(ADDR_MON_ONE, v[15:0]);
      rd(ADDR_MON_ONE, v[15:0]);
      chk(mon_one, v[15:0]);
      u_host.xfer({1'b0, ADDR_MON_ONE, ~v[15:0]}, 23, rd_word);
      rd(ADDR_MON_ONE, v[15:0]);
      // a whole frame sent while the clock enable is low must not land
      ce = 1'b0;
      wr(ADDR_MON_ONE, ~v[15:0]);
      ce = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk(mon_one, v[15:0]);
      rd(ADDR_MON_ONE, v[15:0]);
      // unmapped place reads zero and leaves neighbours alone
      wr(7'h27, 16'hffff);
      rd(7'h27, 16'h0000);
      rd(ADDR_SINK_RAT, 16'hd5c9);
      close_out();
   end
endmodule // test_gate_drive_current_and_amp_gain_regs

// ===== design/gdreg_pkg.sv
package gdreg_pkg;
   // register addresses on the serial port
   localparam logic [6:0]  ADDR_SRC_CODE  = 7'h25;
   localparam logic [6:0]  ADDR_SINK_RAT  = 7'h26;
   localparam logic [6:0]  ADDR_AMP_GAIN  = 7'h29;
   localparam logic [6:0]  ADDR_MON_ONE   = 7'h2B;
   // reset values
   localparam logic [15:0] RST_SRC_CODE   = 16'h0000;
   localparam logic [15:0] RST_SINK_RAT   = 16'h0000;
   localparam logic [15:0] RST_AMP_GAIN   = 16'h0000;
   localparam logic [15:0] RST_MON_ONE    = 16'h4002;
   // writable masks, reserved bits read zero
   localparam logic [15:0] MASK_SRC_CODE  = 16'h3F3F;
   localparam logic [15:0] MASK_SINK_RAT  = 16'hFFFF;
   localparam logic [15:0] MASK_AMP_GAIN  = 16'h8FFF;
   localparam logic [15:0] MASK_MON_ONE   = 16'hFFFF;
   // field positions
   localparam int HI_RATIO_MSB = 15;
   localparam int HI_CODE_MSB  = 13;
   localparam int HI_CODE_LSB  = 8;
   localparam int LO_RATIO_MSB = 7;
   localparam int LO_CODE_MSB  = 5;
   localparam int LO_CODE_LSB  = 0;
   localparam int REF_DIV_BIT  = 15;
   localparam int GAIN_W       = 4;
   // serial frame: read flag, 7-bit address, 16-bit data
   localparam int          FRAME_BITS = 24;
   localparam logic [4:0]  FRAME_LEN  = 5'h18;
   localparam logic [4:0]  HDR_LAST   = 5'h07;
   localparam int          RD_FLAG    = 23;
   // sink code from which the ratio no longer matters
   localparam logic [5:0]  SINK_STRONG = 6'h24;
   // gain values, code 1000b and above all give the top gain
   localparam logic [5:0]  GAIN_5  = 6'h05;
   localparam logic [5:0]  GAIN_10 = 6'h0A;
   localparam logic [5:0]  GAIN_12 = 6'h0C;
   localparam logic [5:0]  GAIN_16 = 6'h10;
   localparam logic [5:0]  GAIN_20 = 6'h14;
   localparam logic [5:0]  GAIN_23 = 6'h17;
   localparam logic [5:0]  GAIN_25 = 6'h19;
   localparam logic [5:0]  GAIN_30 = 6'h1E;
   localparam logic [5:0]  GAIN_40 = 6'h28;
   // serial engine states
   typedef enum logic {GDREG_IDLE, GDREG_SHIFT} gdreg_state_t;
endpackage

// ===== design/gdreg_top.sv
`timescale 1ns/1ps
// How it works
// - high ratio used only when select is 0
// - low ratio used only when select is 0
// - ratio codes scale source: 1, .75, .5, .25
// - bits 13..8 hold high-side sink code
// - bits 5..0 hold low-side sink code
// - drive register at 26h resets to 0000h
// - bit 15 selects reference divide half/eighth
// - bits 11..8 hold gain code channel A
// - bits 7..4 hold gain code channel B
// - bits 3..0 hold gain code channel C
// - gain codes map to 5 through 40
// - gain codes 1001b..1111b give 40
// - gain changes apply at once while running
// - amp register at 29h, reserved 14..12 read-only
// - monitor register at 2Bh resets to 4002h
// - select 1 uses programmed source codes instead
module gdreg_top
   import gdreg_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_sclk,
   input  wire logic       spi_mosi,
   input  wire logic       source_current_config_select,
   output logic            spi_miso,
   output logic            spi_miso_oe,
   output logic [5:0]      high_side_sink_current_code,
   output logic [5:0]      low_side_sink_current_code,
   output logic [5:0]      high_side_source_eff,
   output logic [5:0]      low_side_source_eff,
   output logic            reference_divide_select,
   output logic [5:0]      amp_gain_value_a,
   output logic [5:0]      amp_gain_value_b,
   output logic [5:0]      amp_gain_value_c,
   output logic [15:0]     supply_monitor_control_one
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [3:0]   sync1_r;          // first stage, read only by second stage
   logic [3:0]   sync2_r;          // {cfg, mosi, sclk, cs_n}
   logic         sclk_d_r;         // previous synced clock for edges
   logic         cs_n_d_r;         // previous synced select

   // two flops on every serial and select pin before any logic looks at it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= 4'h1;
         sync2_r <= 4'h1;
      end else if (ce) begin
         sync1_r <= {source_current_config_select, spi_mosi, spi_sclk, spi_cs_n};
         sync2_r <= sync1_r;
      end
   end

   logic cs_n_s;
   logic sclk_s;
   logic mosi_s;
   logic cfg_sel_s;
   assign cs_n_s    = sync2_r[0];
   assign sclk_s    = sync2_r[1];
   assign mosi_s    = sync2_r[2];
   assign cfg_sel_s = sync2_r[3];

   // edge history
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else if (ce) begin
         sclk_d_r <= sclk_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_end;
   assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;
   assign cs_end    = cs_n_s & ~cs_n_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // serial frame engine
   gdreg_state_t             state_r;   // idle or shifting
   logic [FRAME_BITS-1:0]    rx_r;      // received bits, msb first
   logic [4:0]               cnt_r;     // bits received this frame
   logic [15:0]              tx_r;      // read data shifted out
   logic [15:0]              rd_data;   // register addressed by header
   logic                     wr_stb;    // one-cycle write commit

   // a frame commits only when exactly 24 bits came in; short or long
   // frames are dropped so a glitching select cannot corrupt settings
   assign wr_stb = ce && cs_end && (state_r == GDREG_SHIFT)
                   && (cnt_r == FRAME_LEN) && !rx_r[RD_FLAG];

   // state and receive shifter
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= GDREG_IDLE;
         rx_r    <= '0;
         cnt_r   <= '0;
      end else if (ce) begin
         case (state_r)
            GDREG_IDLE: begin
               cnt_r <= '0;
               if (!cs_n_s) begin
                  state_r <= GDREG_SHIFT;
               end
            end
            GDREG_SHIFT: begin
               if (cs_n_s) begin
                  state_r <= GDREG_IDLE;
               end else if (sclk_rise) begin
                  rx_r  <= {rx_r[FRAME_BITS-2:0], mosi_s};
                  // saturate so an overlong frame never wraps back to 24
                  if (cnt_r != 5'h1F) begin
                     cnt_r <= cnt_r + 5'h01;
                  end
               end
            end
            default: begin
               state_r <= GDREG_IDLE;
            end
         endcase
      end
   end

   // header address, valid on the eighth rising edge while that bit is still on mosi
   logic [6:0] hdr_addr;
   assign hdr_addr = {rx_r[5:0], mosi_s};

   // transmit shifter: loaded at header end, moved out on falling edges
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tx_r        <= '0;
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else if (ce) begin
         spi_miso_oe <= (state_r == GDREG_SHIFT) && !cs_n_s;
         if (state_r != GDREG_SHIFT) begin
            tx_r     <= '0;
            spi_miso <= 1'b0;
         end else if (sclk_rise && cnt_r == HDR_LAST) begin
            tx_r <= rd_data;
         end else if (sclk_fall && cnt_r > HDR_LAST) begin
            spi_miso <= tx_r[15];
            tx_r     <= {tx_r[14:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register bank
   logic [15:0] src_code_r;   // source current codes
   logic [15:0] sink_rat_r;   // sink codes and ratios
   logic [15:0] amp_gain_r;   // divider and gain codes
   logic [15:0] mon_one_r;    // first monitor control
   logic [6:0]  wr_addr;
   logic [15:0] wr_data;
   assign wr_addr = rx_r[22:16];
   assign wr_data = rx_r[15:0];

   // read mux; unmapped addresses answer zero
   always_comb begin
      case (hdr_addr)
         ADDR_SRC_CODE: rd_data = src_code_r;
         ADDR_SINK_RAT: rd_data = sink_rat_r;
         ADDR_AMP_GAIN: rd_data = amp_gain_r;
         ADDR_MON_ONE:  rd_data = mon_one_r;
         default:       rd_data = '0;
      endcase
   end

   // writes land immediately; gains need no driver stop to change
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         src_code_r <= RST_SRC_CODE;
         sink_rat_r <= RST_SINK_RAT;
         amp_gain_r <= RST_AMP_GAIN;
         mon_one_r  <= RST_MON_ONE;
      end else if (wr_stb) begin
         case (wr_addr)
            ADDR_SRC_CODE: src_code_r <= wr_data & MASK_SRC_CODE;
            ADDR_SINK_RAT: sink_rat_r <= wr_data & MASK_SINK_RAT;
            ADDR_AMP_GAIN: amp_gain_r <= wr_data & MASK_AMP_GAIN;
            ADDR_MON_ONE:  mon_one_r  <= wr_data & MASK_MON_ONE;
            default: begin
               // unmapped: write dropped
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // drive current derivation
   // scale a sink code by the ratio; truncation keeps source at or below
   // the true product, the safe side for gate stress
   function automatic logic [5:0] scale_src(input logic [5:0] sink,
                                            input logic [1:0] ratio);
      logic [7:0] prod;
      prod = 8'h00;
      case (ratio)
         2'b00:   prod = {sink, 2'b00};
         2'b01:   prod = {sink, 2'b00} - {2'b00, sink};
         2'b10:   prod = {1'b0, sink, 1'b0};
         default: prod = {2'b00, sink};
      endcase
      if (sink >= SINK_STRONG) begin
         prod = {sink, 2'b00};
      end
      return prod[7:2];
   endfunction

   logic [5:0] hi_sink;
   logic [5:0] lo_sink;
   logic [1:0] hi_ratio;
   logic [1:0] lo_ratio;
   assign hi_sink  = sink_rat_r[HI_CODE_MSB:HI_CODE_LSB];
   assign lo_sink  = sink_rat_r[LO_CODE_MSB:LO_CODE_LSB];
   assign hi_ratio = sink_rat_r[HI_RATIO_MSB -: 2];
   assign lo_ratio = sink_rat_r[LO_RATIO_MSB -: 2];

   // registered drive settings
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         high_side_sink_current_code <= '0;
         low_side_sink_current_code  <= '0;
         high_side_source_eff        <= '0;
         low_side_source_eff         <= '0;
         supply_monitor_control_one  <= RST_MON_ONE;
      end else if (ce) begin
         high_side_sink_current_code <= hi_sink;
         low_side_sink_current_code  <= lo_sink;
         supply_monitor_control_one  <= mon_one_r;
         if (cfg_sel_s) begin
            high_side_source_eff <= src_code_r[HI_CODE_MSB:HI_CODE_LSB];
            low_side_source_eff  <= src_code_r[LO_CODE_MSB:LO_CODE_LSB];
         end else begin
            high_side_source_eff <= scale_src(hi_sink, hi_ratio);
            low_side_source_eff  <= scale_src(lo_sink, lo_ratio);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // amplifier gain decode
   function automatic logic [5:0] gain_of(input logic [GAIN_W-1:0] code);
      case (code)
         4'h0:    return GAIN_5;
         4'h1:    return GAIN_10;
         4'h2:    return GAIN_12;
         4'h3:    return GAIN_16;
         4'h4:    return GAIN_20;
         4'h5:    return GAIN_23;
         4'h6:    return GAIN_25;
         4'h7:    return GAIN_30;
         default: return GAIN_40;
      endcase
   endfunction

   logic [5:0] gain_r [3];   // index 2 = A, 1 = B, 0 = C

   // one decoder per channel, channel C in the lowest nibble
   for (genvar ch = 0; ch < 3; ch++) begin : g_gain
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            gain_r[ch] <= GAIN_5;
         end else if (ce) begin
            gain_r[ch] <= gain_of(amp_gain_r[ch*GAIN_W +: GAIN_W]);
         end
      end
   end

   assign amp_gain_value_a = gain_r[2];
   assign amp_gain_value_b = gain_r[1];
   assign amp_gain_value_c = gain_r[0];

   // reference divider select
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reference_divide_select <= 1'b0;
      end else if (ce) begin
         reference_divide_select <= amp_gain_r[REF_DIV_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_write(logic [6:0] a);
      wr_stb && wr_addr == a;
   endsequence

   a_sink_write_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_write(ADDR_SINK_RAT) |=> sink_rat_r == $past(wr_data))
      else $error("drive register write lost");

   a_amp_reserved_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      amp_gain_r[14:12] == 3'h0 && src_code_r[15:14] == 2'h0)
      else $error("reserved bits not zero");

   a_gain_write_live: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_write(ADDR_AMP_GAIN) ##1 ce ##1 ce |-> amp_gain_value_a ==
      gain_of($past(wr_data[11:8], 2)))
      else $error("gain change not applied");

   a_gain_saturate: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && amp_gain_r[7:4] > 4'h8 |=> amp_gain_value_b == GAIN_40)
      else $error("high gain code not saturated");

   a_gain_lowest: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && amp_gain_r[3:0] == 4'h0 |=> amp_gain_value_c == GAIN_5)
      else $error("gain code zero not five");

   a_ref_div_follow: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce |=> reference_divide_select == $past(amp_gain_r[REF_DIV_BIT]))
      else $error("divide select stale");

   a_ratio_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && cfg_sel_s |=> high_side_source_eff ==
      $past(src_code_r[HI_CODE_MSB:HI_CODE_LSB]))
      else $error("programmed source not used");

   a_ratio_half: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && !cfg_sel_s && lo_ratio == 2'b10 && lo_sink < SINK_STRONG
      |=> low_side_source_eff == {1'b0, $past(lo_sink[5:1])})
      else $error("half ratio wrong");

   a_strong_sink: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && !cfg_sel_s && hi_sink >= SINK_STRONG
      |=> high_side_source_eff == $past(hi_sink))
      else $error("ratio applied to strong sink");

   a_short_frame_drop: assert property (@(posedge sys_clk) disable iff (!resetn)
      cs_end && cnt_r != FRAME_LEN |=> $stable(mon_one_r))
      else $error("short frame wrote register");

endmodule // gdreg_top
